// File: logic/brsm_pkg.sv
// package for the back-up / reset / stop mode sequencer
// assumes one 200 MHz core clock and synchronous active-high reset
package brsm_pkg;
   localparam int unsigned CLK_PERIOD_PS = 5000;
   // oscillator warm-up time, in ns
   localparam int unsigned WARMUP_NS = 100_000;
   localparam int unsigned WARMUP_CYCLES = (WARMUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [7:0] STOP_KEY_VALUE = 8'hA5;
   localparam logic [7:0] STOP_KEY_RESET = 8'h00;
   localparam int unsigned PIN_COUNT = 38;
   localparam int unsigned TIMER_CLK_PIN_IDX = 0;
   localparam int unsigned CAPTURE_PIN_IDX = 1;

   typedef enum logic [1:0] {
      BRSM_BACKUP = 2'b00,
      BRSM_RESET = 2'b01,
      BRSM_RUN = 2'b11,
      BRSM_STOP = 2'b10
   } brsm_state_t;
endpackage

// File: logic/brsm_sequencer.sv
// back-up / reset-status / stop mode sequencer with pad overrides
// assumes all inputs synchronous to core_clk_i; cpu drives key writes and stop
//
// Contract
// - hold back-up while reset pin low or supply below detect threshold
// - enter reset status on reset pin rise, supply rise, or watchdog overflow
// - back-up floats pins except two pins, disables pull-ups, blocks inputs
// - back-up forces all ports to input mode with input path gated except on the two kept pins
// - reset status floats pins except two pins and disables pull-ups
// - back-up and reset status reinitialise all control and system registers
// - leave back-up on reset pin high or supply rising-edge indication
// - leave reset status only after oscillator warm-up interval
// - stop keeps port configuration and output data unchanged
// - leave stop on external interrupt, reset, or edge-wake event
`timescale 1ns/10ps
module brsm_sequencer
   import brsm_pkg::*;
#(
   parameter int unsigned WARMUP = brsm_pkg::WARMUP_CYCLES,
   parameter int unsigned PINS = brsm_pkg::PIN_COUNT
) (
   input wire logic core_clk_i, // core clock
   input wire logic reset_i, // synchronous reset, active high
   input wire logic ext_reset_pin_n_i, // external reset pin, active low
   input wire logic supply_low_i, // supply below supply_detect_threshold
   input wire logic supply_rise_i, // supply rising-edge pulse from detector
   input wire logic wdt_overflow_i, // watchdog overflow pulse
   input wire logic ext_irq_i, // external interrupt request
   input wire logic edge_wake_i, // stop_edge_wake_circuit event
   input wire logic key_wr_i, // write strobe to stop_key_register
   input wire logic [7:0] key_wdata_i, // data for stop_key_register
   input wire logic stop_exec_i, // stop instruction executes
   input wire logic [PINS-1:0] port_oe_i, // core output enables
   input wire logic [PINS-1:0] port_pu_i, // core pull-up enables
   input wire logic [PINS-1:0] port_out_i, // core output data
   output logic [PINS-1:0] pad_oe_o, // pad output enables
   output logic [PINS-1:0] pad_pu_o, // pad pull-up enables
   output logic [PINS-1:0] pad_out_o, // pad output data
   output logic [PINS-1:0] pad_in_en_o, // pad input path enables
   output logic sys_reset_o, // reinitialise control/system registers
   output logic core_clk_en_o, // core clock running (low in stop)
   output logic [1:0] mode_o, // current mode code
   output logic [7:0] stop_key_o // stop_key_register contents
);
   import brsm_pkg::*;

   localparam int CW = $clog2(WARMUP + 1);
   localparam logic [CW-1:0] WARM_LAST = CW'(WARMUP - 1);

   brsm_state_t state_q, state_d;
   logic [CW-1:0] warm_q, warm_d;
   logic [7:0] key_q, key_d;
   logic pin_q, pin_d;
   logic [PINS-1:0] oe_q, oe_d, pu_q, pu_d, out_q, out_d, ien_q, ien_d;
   logic pin_rise, backup_cond, reset_evt;
   logic [PINS-1:0] keep_mask;

   always_comb begin
      keep_mask = '0;
      keep_mask[TIMER_CLK_PIN_IDX] = 1'b1;
      keep_mask[CAPTURE_PIN_IDX] = 1'b1;
   end

   assign pin_rise = ext_reset_pin_n_i && !pin_q;
   assign backup_cond = !ext_reset_pin_n_i || supply_low_i;
   assign reset_evt = pin_rise || supply_rise_i || wdt_overflow_i;

   always_comb begin
      state_d = state_q;
      warm_d = warm_q;
      key_d = key_q;
      pin_d = ext_reset_pin_n_i;
      if (backup_cond) begin
         state_d = BRSM_BACKUP;
      end else begin
         unique case (state_q)
            BRSM_BACKUP: begin
               // pin high again or supply back: go through warm-up
               if (pin_rise || supply_rise_i || !supply_low_i) begin
                  state_d = BRSM_RESET;
                  warm_d = '0;
               end
            end
            BRSM_RESET: begin
               if (reset_evt) begin
                  warm_d = '0;
               end else if (warm_q == WARM_LAST) begin
                  state_d = BRSM_RUN;
               end else begin
                  warm_d = warm_q + CW'(1);
               end
            end
            BRSM_RUN: begin
               if (reset_evt) begin
                  state_d = BRSM_RESET;
                  warm_d = '0;
               end else if (stop_exec_i && key_q == STOP_KEY_VALUE) begin
                  state_d = BRSM_STOP;
               end
            end
            BRSM_STOP: begin
               if (reset_evt) begin
                  state_d = BRSM_RESET;
                  warm_d = '0;
               end else if (ext_irq_i || edge_wake_i) begin
                  state_d = BRSM_RUN;
               end
            end
         endcase
      end
      if (state_d == BRSM_BACKUP || state_d == BRSM_RESET) begin
         key_d = STOP_KEY_RESET;
      end else if (key_wr_i && state_q == BRSM_RUN) begin
         key_d = key_wdata_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         state_q <= BRSM_BACKUP;
         warm_q <= '0;
         key_q <= STOP_KEY_RESET;
         // idle level of the pin, so a high pin at release is no false rise
         pin_q <= 1'b1;
      end else begin
         state_q <= state_d;
         warm_q <= warm_d;
         key_q <= key_d;
         pin_q <= pin_d;
      end
   end

   // pad overrides; registered so data outputs come from flops
   always_comb begin
      oe_d = port_oe_i;
      pu_d = port_pu_i;
      out_d = port_out_i;
      ien_d = '1;
      unique case (state_d)
         BRSM_BACKUP: begin
            oe_d = '0;
            pu_d = keep_mask;
            out_d = '0;
            ien_d = keep_mask;
         end
         BRSM_RESET: begin
            oe_d = '0;
            pu_d = keep_mask;
            out_d = '0;
         end
         BRSM_STOP: begin
            // core is frozen, so hold whatever stood before
            oe_d = oe_q;
            pu_d = pu_q;
            out_d = out_q;
            ien_d = ien_q;
         end
         BRSM_RUN: begin
            oe_d = port_oe_i;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         // reset lands in back-up, so pads start the way back-up wants them
         oe_q <= '0;
         pu_q <= keep_mask;
         out_q <= '0;
         ien_q <= keep_mask;
      end else begin
         oe_q <= oe_d;
         pu_q <= pu_d;
         out_q <= out_d;
         ien_q <= ien_d;
      end
   end

   assign pad_oe_o = oe_q;
   assign pad_pu_o = pu_q;
   assign pad_out_o = out_q;
   assign pad_in_en_o = ien_q;
   assign sys_reset_o = state_q == BRSM_BACKUP || state_q == BRSM_RESET;
   assign core_clk_en_o = state_q != BRSM_STOP;
   assign mode_o = state_q;
   assign stop_key_o = key_q;

   // second, independent count of edges spent in reset status, so the
   // warm-up check does not lean on the counter it guards
   localparam logic [CW:0] WARM_SPAN = (CW+1)'(WARMUP);
   logic [CW:0] dwell_q, dwell_d;

   always_comb begin
      dwell_d = '0;
      if (state_q == BRSM_RESET && !reset_evt) begin
         dwell_d = dwell_q + (CW+1)'(1);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         dwell_q <= '0;
      end else begin
         dwell_q <= dwell_d;
      end
   end

   // wake from stop also raises run, so the warm-up checks look only at reset exits

   a_backup_entry: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      backup_cond |=> state_q == BRSM_BACKUP
   ) else $error("backup not entered");

   a_run_reset_evt: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      state_q == BRSM_RUN && reset_evt && !backup_cond |=> state_q == BRSM_RESET
   ) else $error("reset status not entered");

   a_backup_pads: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      state_q == BRSM_BACKUP && $past(state_q) == BRSM_BACKUP |->
      pad_oe_o == '0 && pad_pu_o == keep_mask && pad_in_en_o == keep_mask
   ) else $error("backup pads wrong");

   a_backup_float: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      backup_cond |=> pad_oe_o == '0 && (pad_pu_o & ~keep_mask) == '0
   ) else $error("backup pins not floating");

   a_backup_input: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      backup_cond |=> (pad_in_en_o & ~keep_mask) == '0
   ) else $error("input not gated");

   a_reset_pads: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      state_d == BRSM_RESET |=> pad_oe_o == '0 && pad_pu_o == keep_mask
   ) else $error("reset pads wrong");

   a_sys_reset: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      sys_reset_o |-> stop_key_o == STOP_KEY_RESET
   ) else $error("key not reset");

   a_reset_regs: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      state_d == BRSM_RESET |=> sys_reset_o && stop_key_o == STOP_KEY_RESET
   ) else $error("registers not reinitialised");

   a_backup_exit: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      state_q == BRSM_BACKUP && !backup_cond |=> state_q == BRSM_RESET
   ) else $error("backup not left");

   a_warmup_hold: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      $rose(state_q == BRSM_RUN) && $past(state_q) != BRSM_STOP |->
      $past(state_q) == BRSM_RESET && $past(warm_q) == WARM_LAST
   ) else $error("warm-up cut short");

   a_warm_early: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      state_q == BRSM_RESET && warm_q != WARM_LAST |=> state_q != BRSM_RUN
   ) else $error("run before warm-up end");

   a_warm_span: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      $rose(state_q == BRSM_RUN) && $past(state_q) == BRSM_RESET |-> dwell_q == WARM_SPAN
   ) else $error("warm-up length wrong");

   a_stop_hold: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      state_q == BRSM_STOP && state_d == BRSM_STOP |=>
      $stable(pad_oe_o) && $stable(pad_out_o)
   ) else $error("stop pads moved");

   a_stop_pullup: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      state_q == BRSM_STOP && state_d == BRSM_STOP |=>
      $stable(pad_pu_o) && $stable(pad_in_en_o)
   ) else $error("stop pad config moved");

   a_stop_wake: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      state_q == BRSM_STOP && (ext_irq_i || edge_wake_i) |=> state_q != BRSM_STOP
   ) else $error("stop not released");

   a_stop_release: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      state_q == BRSM_STOP && !backup_cond && !reset_evt && (ext_irq_i || edge_wake_i)
      |=> state_q == BRSM_RUN
   ) else $error("wake did not resume run");

   a_stop_reset: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      state_q == BRSM_STOP && reset_evt && !backup_cond |=> state_q == BRSM_RESET
   ) else $error("reset did not leave stop");

   a_stop_stay: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      state_q == BRSM_STOP && !backup_cond && !reset_evt && !ext_irq_i && !edge_wake_i
      |=> state_q == BRSM_STOP
   ) else $error("stop left without cause");

   a_stop_key: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      state_q == BRSM_RUN && stop_exec_i && key_q != STOP_KEY_VALUE |=> state_q != BRSM_STOP
   ) else $error("stop without key");

   a_stop_entry: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      state_q == BRSM_RUN && stop_exec_i && key_q == STOP_KEY_VALUE && !reset_evt &&
      !backup_cond |=> state_q == BRSM_STOP
   ) else $error("keyed stop not entered");
endmodule

// File: test/brsm_partner.sv
// far-side model: external reset pin, supply detector and wake sources
// assumes tasks are called from a process synchronous to core_clk_i
`timescale 1ns/10ps
module brsm_partner (
   input wire logic core_clk_i, // core clock
   output logic ext_reset_pin_n_o, // external reset pin, active low
   output logic supply_low_o, // supply below supply_detect_threshold
   output logic [3:0] event_o // {edge wake, irq, watchdog, supply rise}
);
   initial begin
      ext_reset_pin_n_o = 1'b0;
      supply_low_o = 1'b0;
      event_o = 4'h0;
   end
   // events are single-cycle, as a detector edge or an overflow would be
   always @(posedge core_clk_i) begin
      if (event_o != 4'h0)
         event_o <= 4'h0;
   end
   task automatic pin(input logic lvl);
      @(posedge core_clk_i);
      ext_reset_pin_n_o <= lvl;
   endtask
   task automatic low(input logic lvl);
      @(posedge core_clk_i);
      supply_low_o <= lvl;
   endtask
   task automatic pulse(input int unsigned w);
      @(posedge core_clk_i);
      event_o <= 4'h1 << w;
   endtask
endmodule

// File: test/brsm_sequencer_tb.sv
// self-checking bench for the mode sequencer with random pad traffic
// assumes brsm_pkg and brsm_partner are compiled first
`timescale 1ns/10ps
module brsm_sequencer_tb;
   import brsm_pkg::*;
   localparam int unsigned WU = 8;
   localparam int unsigned NP = 38;
   localparam logic [NP-1:0] KEEP = 38'h00_0000_0003;
   logic core_clk_i, reset_i, key_wr_i, stop_exec_i, pin_n, sup_low, sys_reset_o, core_clk_en_o;
   logic [3:0] ev;
   logic [1:0] mode_o;
   logic [7:0] key_wdata_i, stop_key_o;
   logic [NP-1:0] port_oe_i, port_pu_i, port_out_i, pad_oe_o, pad_pu_o, pad_out_o, pad_in_en_o;
   logic [NP-1:0] s_oe, s_out;
   int unsigned n_mismatch = 0, n_tests = 0, n;
   brsm_partner far_u (.core_clk_i(core_clk_i), .ext_reset_pin_n_o(pin_n),
      .supply_low_o(sup_low), .event_o(ev));
   brsm_sequencer #(.WARMUP(WU), .PINS(NP)) dut_u (.core_clk_i, .reset_i,
      .ext_reset_pin_n_i(pin_n), .supply_low_i(sup_low), .supply_rise_i(ev[0]),
      .wdt_overflow_i(ev[1]), .ext_irq_i(ev[2]), .edge_wake_i(ev[3]), .key_wr_i,
      .key_wdata_i, .stop_exec_i, .port_oe_i, .port_pu_i, .port_out_i, .pad_oe_o,
      .pad_pu_o, .pad_out_o, .pad_in_en_o, .sys_reset_o, .core_clk_en_o, .mode_o, .stop_key_o);
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      if (n_mismatch == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic tick();
      @(posedge core_clk_i);
      #1;
   endtask
   task automatic rnd_ports();
      @(posedge core_clk_i);
      port_oe_i <= NP'({$urandom(), $urandom()});
      port_pu_i <= NP'({$urandom(), $urandom()});
      port_out_i <= NP'({$urandom(), $urandom()});
      // stray key writes: taken only in run, cleared by reset status
      key_wr_i <= 1'($urandom());
      key_wdata_i <= 8'($urandom());
   endtask
   task automatic chk_backup();
      chk(mode_o, BRSM_BACKUP);
      chk(pad_oe_o, 0);
      chk(pad_pu_o, KEEP);
      chk(pad_in_en_o, KEEP);
      chk({sys_reset_o, stop_key_o}, 9'h100);
   endtask
   // counts edges spent in reset status before run resumes
   task automatic to_run();
      tick();
      chk(mode_o, BRSM_RESET);
      chk(pad_oe_o & ~KEEP, 0);
      chk(pad_pu_o, KEEP);
      chk({sys_reset_o, stop_key_o}, 9'h100);
      n = 0;
      do begin
         tick();
         n++;
      end while (mode_o === BRSM_RESET && n < 100);
      chk(n, WU);
      chk(mode_o, BRSM_RUN);
   endtask
   task automatic go_stop(input logic [7:0] key);
      @(posedge core_clk_i);
      key_wr_i <= 1'b1;
      key_wdata_i <= key;
      @(posedge core_clk_i);
      key_wr_i <= 1'b0;
      stop_exec_i <= 1'b1;
      @(posedge core_clk_i);
      stop_exec_i <= 1'b0;
      #1;
      chk(mode_o, key === STOP_KEY_VALUE ? BRSM_STOP : BRSM_RUN);
   endtask
   initial begin
      core_clk_i = 1'b0;
      forever #2.5 core_clk_i = ~core_clk_i;
   end
   initial begin
      #20_000;
      n_mismatch++;
      give_verdict();
   end
   initial begin
      void'($urandom(50259));
      {reset_i, key_wr_i, stop_exec_i, key_wdata_i} = 11'h400;
      {port_oe_i, port_pu_i, port_out_i} = '0;
      repeat (8) @(posedge core_clk_i);
      reset_i <= 1'b0;
      rnd_ports();
      repeat (3) tick();
      chk_backup();
      far_u.pin(1'b1);
      to_run();
      go_stop(8'hA4);
      go_stop(8'hA6);
      go_stop(8'($urandom_range(164)));
      for (int w = 1; w < 4; w++) begin
         rnd_ports();
         go_stop(STOP_KEY_VALUE);
         s_oe = pad_oe_o;
         s_out = pad_out_o;
         rnd_ports();
         tick();
         chk(pad_oe_o, s_oe);
         chk(pad_out_o, s_out);
         chk(core_clk_en_o, 1'b0);
         far_u.pulse(w);
         if (w == 1)
            to_run();
         else begin
            tick();
            chk(mode_o, BRSM_RUN);
         end
         chk(core_clk_en_o, 1'b1);
      end
      far_u.pulse(0);
      to_run();
      far_u.low(1'b1);
      tick();
      chk_backup();
      far_u.low(1'b0);
      to_run();
      go_stop(STOP_KEY_VALUE);
      far_u.pin(1'b0);
      tick();
      chk_backup();
      far_u.pin(1'b1);
      to_run();
      give_verdict();
   end
endmodule
